// File: bench/tb_ulm_mapper.sv
/* Self-checking testbench for ulm_mapper with far-end model.
   Assumes 200 MHz clk and synchronous active-high reset. */
`timescale 1ns/1ps
`include "ulm_params.svh"
module tb_ulm_mapper;
  logic clk, rst, app_bit_en, app_bit, signal_loss_pin, other_fault, core_req, loss_m;
  logic rx_payload_valid, section_operational, signal_loss, app_out_bit, app_out_valid;
  logic [7:0]                         rx_payload, last_b;
  logic [`ULM_OH_BITS-1:0]            frame_overhead_bits;
  ulm_pkg::ulm_pair_stat_t [2:0]      pair_stat_pin;
  ulm_pkg::ulm_frame_byte_t           frame_byte;
  int                                 bad_count, n_tests, idx;
  logic [7:0]                         m_sh;
  logic                               m_bit;
  ulm_mapper dut (.clk, .rst, .app_bit_en, .app_bit, .signal_loss_pin, .other_fault,
    .pair_stat_pin, .core_req, .rx_payload, .rx_payload_valid, .frame_byte,
    .frame_overhead_bits, .section_operational, .signal_loss, .app_out_bit, .app_out_valid);
  ulm_far_end far (.clk, .rst, .frame_byte, .rx_payload, .rx_payload_valid);
  // Customer-side output model: ones until all pairs are up, then MSB first
  always @(posedge clk) begin
    if (rst) begin
      m_sh  <= 8'hFF;
      m_bit <= 1'b1;
    end else if (rx_payload_valid) begin
      m_sh <= rx_payload;
    end else if (app_bit_en) begin
      m_sh  <= {m_sh[6:0], 1'b1};
      m_bit <= (&pair_stat_pin) ? m_sh[7] : 1'b1;
    end
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    for (int j = 7; j >= 0; j--) begin
      app_bit = b[j];
      app_bit_en = 1'b1;
      @(negedge clk);
      app_bit_en = 1'b0;
      chk(app_out_valid, &pair_stat_pin);
      chk(app_out_bit, m_bit);
      @(negedge clk);
    end
    last_b = b;
  endtask
  task automatic req(input int n);
    logic st;
    core_req = 1'b1;
    repeat (n) begin
      @(negedge clk);
      st = idx >= `ULM_PAYLOAD_BYTES;
      chk(frame_byte, {1'b1, idx == 0, st, (loss_m | st) ? 8'hFF : last_b});
      idx = (idx == `ULM_FRAME_BYTES - 1) ? 0 : idx + 1;
    end
    core_req = 1'b0;
    @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
  initial begin
    {rst, app_bit_en, app_bit, signal_loss_pin, other_fault, core_req, loss_m} = 7'h40;
    pair_stat_pin = 6'h00;
    {bad_count, n_tests, idx} = 0;
    last_b = 8'hFF;
    void'($urandom(32'h7291));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < `ULM_PAYLOAD_BYTES; i++) begin
        send(8'($urandom));
        req(1);
      end
      req(`ULM_STUFF_BYTES);
    end
    signal_loss_pin = 1'b1;
    loss_m = 1'b1;
    repeat (10) @(negedge clk);
    chk(signal_loss, 1'b1);
    chk(frame_overhead_bits, {{33{1'b1}}, 1'b0, {14{1'b1}}});
    req(`ULM_FRAME_BYTES);
    signal_loss_pin = 1'b0;
    loss_m = 1'b0;
    repeat (10) @(negedge clk);
    chk(frame_overhead_bits, {48{1'b1}});
    send(8'h5A);
    req(1);
    chk(far.n_frames, 32'h4);
    for (int k = 0; k < 16; k++) begin
      pair_stat_pin = ($urandom % 2) ? 6'h3F : 6'($urandom);
      other_fault = ($urandom % 4) == 0;
      repeat (10) @(negedge clk);
      chk(section_operational, &pair_stat_pin && !other_fault);
      send(8'($urandom));
    end
    results;
  end
endmodule
bind ulm_mapper ulm_mapper_asserts chk_i (.clk, .rst, .signal_loss_pin, .other_fault,
  .pair_stat_pin, .core_req, .frame_byte, .frame_overhead_bits, .section_operational,
  .signal_loss);

// File: bench/ulm_far_end.sv
/* Far-end terminal model: feeds received payload bytes, counts frames.
   Assumes the mapper frame byte output on clk. */
`timescale 1ns/1ps
module ulm_far_end (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire ulm_pkg::ulm_frame_byte_t frame_byte,
  output logic [7:0]                    rx_payload,
  output logic                          rx_payload_valid
);
  int         n_frames;
  logic [3:0] gap;
  // Inverted data between strobes, never a stale copy
  always @(negedge clk) begin
    if (rst) begin
      gap = 4'h0;
      n_frames = 0;
      rx_payload = 8'h00;
      rx_payload_valid = 1'b0;
    end else begin
      gap = gap + 4'h1;
      rx_payload_valid = (gap == 4'h0);
      rx_payload = rx_payload_valid ? 8'($urandom) : ~rx_payload;
      if (frame_byte.valid && frame_byte.sof) n_frames++;
    end
  end
endmodule

// File: bench/ulm_mapper_asserts.sv
/* Port checker for ulm_mapper.
   Bound to the mapper from the testbench top file. */
`timescale 1ns/1ps
`include "ulm_params.svh"
module ulm_mapper_asserts (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         signal_loss_pin,
  input wire logic                         other_fault,
  input wire ulm_pkg::ulm_pair_stat_t [2:0] pair_stat_pin,
  input wire logic                         core_req,
  input wire ulm_pkg::ulm_frame_byte_t     frame_byte,
  input wire logic [`ULM_OH_BITS-1:0]      frame_overhead_bits,
  input wire logic                         section_operational,
  input wire logic                         signal_loss
);
  logic [7:0] idx_r;
  wire        good = &pair_stat_pin & !other_fault;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Frame byte position
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) idx_r <= 8'h00;
    else if (frame_byte.valid) idx_r <= (idx_r == 8'h8F) ? 8'h00 : idx_r + 8'h01;
  end
  a_answer_next: assert property (1 |=> frame_byte.valid == $past(core_req))
    else $error("byte strobe not one cycle after request");
  a_frame_pos: assert property (frame_byte.valid |->
    frame_byte.sof == (idx_r == 8'h00) && frame_byte.stuff == (idx_r >= 8'h80))
    else $error("start or stuff mark at wrong byte");
  a_stuff_ones: assert property (frame_byte.valid && frame_byte.stuff |->
    frame_byte.data == 8'hFF) else $error("stuff byte not all ones");
  a_spare_ones: assert property (&{frame_overhead_bits[47:15],
    frame_overhead_bits[13:8]}) else $error("spare overhead bit low");
  a_loss_flag: assert property (1 |=>
    frame_overhead_bits[14] == !$past(signal_loss)) else $error("loss flag wrong");
  a_loss_payload: assert property (signal_loss && $past(signal_loss)
    && frame_byte.valid |-> frame_byte.data == 8'hFF) else $error("payload not ones");
  a_loss_seen: assert property (signal_loss_pin [*8] |-> signal_loss)
    else $error("input loss not flagged");
  a_oper_on: assert property (good [*8] |-> section_operational)
    else $error("section not operational");
  a_oper_off: assert property (!(&pair_stat_pin) [*8] |-> !section_operational)
    else $error("section operational with failing pair");
endmodule

// File: hdl/ulm_mapper.sv
/*
  Unstructured 2048 kbit/s leased-line mapper toward the core frame.
  Assumes app bits arrive one per app_bit_en strobe on clk (one every
  ~97.66 clk), core_req pulses request the next frame byte, and
  loss-of-signal and pair status come from pins (synchronised here).
*/
`timescale 1ns/1ps
`include "ulm_params.svh"

module ulm_mapper (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic                                    app_bit_en,
  input  wire logic                                    app_bit,
  input  wire logic                                    signal_loss_pin,
  input  wire logic                                    other_fault,
  input  wire ulm_pkg::ulm_pair_stat_t [`ULM_PAIRS-1:0] pair_stat_pin,
  input  wire logic                                    core_req,
  input  wire logic [7:0]                              rx_payload,
  input  wire logic                                    rx_payload_valid,
  output ulm_pkg::ulm_frame_byte_t                     frame_byte,
  output logic [`ULM_OH_BITS-1:0]                      frame_overhead_bits,
  output logic                                         section_operational,
  output logic                                         signal_loss,
  output logic                                         app_out_bit,
  output logic                                         app_out_valid
);

  localparam int FRAME_CYC = `ULM_FRAME_US * `ULM_CLK_MHZ;
  localparam int TERM_DELAY_CYC = `ULM_TERM_DELAY_US * `ULM_CLK_MHZ;

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [2:0] los_sync_r;
  logic       los_r;
  logic [`ULM_PAIRS*2-1:0] pair_vec;
  logic [`ULM_PAIRS*2-1:0] ps1_r, ps2_r, ps3_r, ps_r;

  assign pair_vec = pair_stat_pin;

  always_ff @(posedge clk) begin
    if (rst) begin
      los_sync_r <= 3'h0;
      los_r      <= 1'b0;
    end else begin
      los_sync_r <= {los_sync_r[1:0], signal_loss_pin};
      if (los_sync_r[1] == los_sync_r[2]) begin
        los_r <= los_sync_r[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ps1_r <= '0;
      ps2_r <= '0;
      ps3_r <= '0;
      ps_r  <= '0;
    end else begin
      ps1_r <= pair_vec;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
      ps_r  <= (ps2_r & ps3_r) | (ps_r & (ps2_r | ps3_r));
    end
  end

  assign signal_loss = los_r;

  // --------------------------------------------------------------
  // Section state
  // --------------------------------------------------------------
  logic [`ULM_PAIRS-1:0] pair_good;
  logic                  all_active;
  logic                  oper_r;

  genvar g;
  generate
    for (g = 0; g < `ULM_PAIRS; g++) begin : g_pair
      // Pair healthy needs activation and correct identity
      assign pair_good[g] = ps_r[2*g+1] & ps_r[2*g];
    end
  endgenerate

  assign all_active = &{ps_r[`ULM_PAIRS*2-1], ps_r[1]} & (&pair_good);

  always_ff @(posedge clk) begin
    if (rst) begin
      oper_r <= 1'b0;
    end else begin
      // One bad pair or any other fault drops the section
      oper_r <= (&pair_good) & ~other_fault;
    end
  end

  assign section_operational = oper_r;

  // --------------------------------------------------------------
  // Bit assembly into payload bytes
  // --------------------------------------------------------------
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] byte_q_r [0:1];
  logic       byte_q_v_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_q_r[0] <= 8'h00;
      byte_q_r[1] <= 8'h00;
      byte_q_v_r <= 1'b0;
    end else begin
      if (app_bit_en) begin
        // Bits are taken as-is; no pattern dependence
        shift_r   <= {shift_r[6:0], app_bit};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          byte_q_r[0] <= {shift_r[6:0], app_bit};
          byte_q_v_r  <= 1'b1;
        end
      end
      if (core_req && byte_q_v_r && !app_bit_en) begin
        byte_q_r[1] <= byte_q_r[0];
        byte_q_v_r  <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Core frame sequencing
  // --------------------------------------------------------------
  logic [7:0]         byte_idx_r;
  ulm_pkg::ulm_phase_t phase;

  always_comb begin
    case (byte_idx_r < 8'(`ULM_PAYLOAD_BYTES))
      1'b1:    phase = ulm_pkg::ULM_PAYLOAD;
      default: phase = ulm_pkg::ULM_STUFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byte_idx_r <= 8'h00;
    end else if (core_req) begin
      if (byte_idx_r == 8'(`ULM_FRAME_BYTES - 1)) begin
        byte_idx_r <= 8'h00;
      end else begin
        byte_idx_r <= byte_idx_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_byte <= '0;
    end else begin
      frame_byte.valid <= core_req;
      frame_byte.sof   <= core_req && (byte_idx_r == 8'h00);
      frame_byte.stuff <= core_req && (phase == ulm_pkg::ULM_STUFF);
      if (!core_req) begin
        frame_byte.data <= frame_byte.data;
      end else if (phase == ulm_pkg::ULM_STUFF) begin
        frame_byte.data <= `ULM_BYTE_ONES;
      end else if (los_r) begin
        frame_byte.data <= `ULM_BYTE_ONES;
      end else begin
        frame_byte.data <= byte_q_r[0];
      end
    end
  end

  // --------------------------------------------------------------
  // Overhead bits sent toward the far unit
  // --------------------------------------------------------------
  generate
    for (g = 1; g <= `ULM_OH_BITS; g++) begin : g_oh
      always_ff @(posedge clk) begin
        if (rst) begin
          frame_overhead_bits[g-1] <= 1'b1;
        end else if (g == `ULM_OH_LOSS_POS) begin
          // Flag low while loss persists, high again once it clears
          frame_overhead_bits[g-1] <= ~los_r;
        end else if (g >= `ULM_OH_SPARE_FIRST && g <= `ULM_OH_SPARE_LAST) begin
          frame_overhead_bits[g-1] <= 1'b1;
        end else begin
          frame_overhead_bits[g-1] <= 1'b1;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Customer-side output; one byte stage keeps delay far below budget
  // --------------------------------------------------------------
  logic [7:0] out_sh_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      out_sh_r      <= 8'hFF;
      app_out_bit   <= 1'b1;
      app_out_valid <= 1'b0;
    end else begin
      app_out_valid <= all_active & app_bit_en;
      if (rx_payload_valid) begin
        out_sh_r <= rx_payload;
      end else if (app_bit_en) begin
        out_sh_r    <= {out_sh_r[6:0], 1'b1};
        app_out_bit <= all_active ? out_sh_r[7] : 1'b1;
      end
    end
  end

endmodule

// File: hdl/ulm_params.svh
/*
  Constants for the unstructured leased-line mapper: frame geometry,
  overhead bit positions and timing counts.
  Assumes a 200 MHz system clock and a 2048 kHz application bit clock.
*/
`ifndef ULM_PARAMS_SVH
`define ULM_PARAMS_SVH

`define ULM_FRAME_BYTES      144
`define ULM_PAYLOAD_BYTES    128
`define ULM_STUFF_BYTES      16
`define ULM_FRAME_US         500
`define ULM_BIT_KBPS         2048
`define ULM_CLK_MHZ          200
`define ULM_OH_BITS          48
`define ULM_OH_LOSS_POS      15
`define ULM_OH_SPARE_FIRST   9
`define ULM_OH_SPARE_LAST    48
`define ULM_SYS_DELAY_US     1250
`define ULM_TERM_DELAY_US    450
`define ULM_REG_DELAY_US     200
`define ULM_LINE_DELAY_US    150
`define ULM_PAIRS            3
`define ULM_BYTE_ONES        8'hFF

`endif

// File: hdl/ulm_pkg.sv
/*
  Types for the unstructured leased-line mapper.
  Constants live in ulm_params.svh.
*/
package ulm_pkg;

  // Status of one transceiver pair
  typedef struct packed {
    logic active;
    logic pair_id_ok;
  } ulm_pair_stat_t;

  // One byte toward the core frame with its position
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       stuff;
    logic [7:0] data;
  } ulm_frame_byte_t;

  typedef enum logic [1:0] {
    ULM_FILL,
    ULM_PAYLOAD,
    ULM_STUFF
  } ulm_phase_t;

endpackage
